// [hdl/tprb_regs.sv]
/*
 Two-wire serial slave and control register bank for the synthesiser,
 RF front end and baseband sections. Assumes bus pins are synchronous
 to core_clk and slow against it; open-drain wire resolved outside.
*/
`timescale 1ns/1ps
module tprb_regs (
	input  wire logic        core_clk,            // Core clock, 40 MHz
	input  wire logic        rst_n,               // Synchronous reset
	input  wire logic        sclIn,               // Serial clock level
	input  wire logic        sdaIn,               // Serial data level
	output logic             sdaOut,              // Serial data drive value
	output logic             sdaOe,               // Serial data drive enable
	input  wire logic        compStrobe,          // Comparison cycle pulse
	input  wire logic        compInLock,          // Comparator in lock
	input  wire logic        subBandStep,         // Sub band needs more pump
	input  wire logic        rfTestIn,            // Read-only RF test bit
	input  wire logic        bbAdjustLockIn,      // Baseband adjust locked
	output logic [14:0]      loDivider,           // Applied divider word
	output logic [1:0]       cpCurrentCode,       // Pump code in use
	output logic [9:0]       cpCurrentUa,         // Pump current, microamps
	output logic [8:0]       refDivRatio,         // Reference divide ratio
	output logic [1:0]       pllTestBits,         // Register 2 test bits
	output logic [7:0]       pllTestCtl,          // PLL test register
	output logic             rfPassthroughOut,    // RF bypass output enable
	output logic             rfGainCut,           // Second RF stage -10 dB
	output logic [4:0]       rfTestBits,          // RF test bits
	output logic [7:0]       bbFilterCode,        // Filter bandwidth code
	output logic             filterAdjustDisableA, // Adjust disable A
	output logic             filterAdjustDisableB, // Adjust disable B
	output logic [4:0]       bbRefDivideRatio,    // Crystal divide ratio
	output logic             bbTestBit,           // Register 6 test bit
	output logic [3:0]       postFilterGainSel,   // Post-filter gain code
	output logic [2:0]       bbTestBits,          // Register 7 test bits
	output logic             synthLockFlag        // Synthesiser lock flag
);

	// ****************************************
	// Declarations
	// ****************************************
	tprb_pkg::tprb_state_t state_q;
	logic       sclQ;
	logic       sdaQ;
	logic       ackPhase_q;
	logic [3:0] bitCnt_q;
	logic [7:0] rxShift_q;
	logic [7:0] txShift_q;
	logic [3:0] subAddr_q;
	logic       sdaOe_q;
	logic       sdaOut_q;
	logic [6:0] divHi_q;
	logic [7:0] divLo_q;
	logic       divHiNew_q;
	logic       divLoNew_q;
	logic [14:0] loDivider_q;
	logic [7:0] cpRef_q;
	logic [1:0] cpInUse_q;
	logic [9:0] cpUa_q;
	logic [8:0] refRatio_q;
	logic [7:0] pllTest_q;
	logic [4:0] rfTest_q;
	logic       bypass_q;
	logic       rfCut_q;
	logic       passthrough_q;
	logic [7:0] bbFilt_q;
	logic [7:0] bbAdj_q;
	logic [3:0] bbGain_q;
	logic [2:0] bbTest_q;
	logic       rfTestRo_q;
	logic       bbLock_q;
	logic       synthLock;

	// ****************************************
	// Bus conditions
	// ****************************************
	// Edges and start/stop from the previous pin samples
	wire sclRise  = sclIn && !sclQ;
	wire sclFall  = !sclIn && sclQ;
	wire busStart = sclIn && sclQ && sdaQ && !sdaIn;
	wire busStop  = sclIn && sclQ && !sdaQ && sdaIn;
	wire byteDone = (bitCnt_q == tprb_pkg::BYTE_BITS);
	wire addrHit  = (rxShift_q[7:1] == tprb_pkg::DEV_ADDR);
	wire rxEnd    = sclFall && !ackPhase_q && byteDone;
	wire wrStrobe = rxEnd && (state_q == tprb_pkg::ST_WR);
	wire [3:0] nextAddr = subAddr_q + 4'h1;

	// Register write selects
	wire weDivHi  = wrStrobe && (subAddr_q == tprb_pkg::A_DIVHI);
	wire weDivLo  = wrStrobe && (subAddr_q == tprb_pkg::A_DIVLO);
	wire weCpRef  = wrStrobe && (subAddr_q == tprb_pkg::A_CPREF);
	wire weTest   = wrStrobe && (subAddr_q == tprb_pkg::A_PLLTEST);
	wire weRf     = wrStrobe && (subAddr_q == tprb_pkg::A_RF);
	wire weBbFilt = wrStrobe && (subAddr_q == tprb_pkg::A_BBFILT);
	wire weBbAdj  = wrStrobe && (subAddr_q == tprb_pkg::A_BBADJ);
	wire weBbGain = wrStrobe && (subAddr_q == tprb_pkg::A_BBGAIN);

	// Both halves programmed: hand the word to the divider
	wire divCommit = divHiNew_q && divLoNew_q;

	// Pump code after the sub band step, saturating at the top code
	wire [1:0] cpProg = cpRef_q[5:4];
	wire [1:0] cpStep = (subBandStep && (cpProg != tprb_pkg::CP_TOP)) ?
		cpProg + 2'h1 : cpProg;

	// ****************************************
	// Readback
	// ****************************************
	// Read-only bits show internal state; unmapped addresses read zero
	function automatic logic [7:0] readReg(input logic [3:0] a);
		case (a)
			tprb_pkg::A_DIVHI:   readReg = {synthLock, divHi_q};
			tprb_pkg::A_DIVLO:   readReg = divLo_q;
			tprb_pkg::A_CPREF:   readReg = {cpRef_q[7:6], cpInUse_q,
				cpRef_q[3:0]};
			tprb_pkg::A_PLLTEST: readReg = pllTest_q;
			tprb_pkg::A_RF:      readReg = {rfTestRo_q, rfTest_q,
				bypass_q, rfCut_q};
			tprb_pkg::A_BBFILT:  readReg = bbFilt_q;
			tprb_pkg::A_BBADJ:   readReg = bbAdj_q;
			tprb_pkg::A_BBGAIN:  readReg = {bbLock_q, bbGain_q, bbTest_q};
			default:             readReg = 8'h00;
		endcase
	endfunction

	wire [7:0] rdCur  = readReg(subAddr_q);
	wire [7:0] rdNext = readReg(nextAddr);

	// ****************************************
	// Lock detector
	// ****************************************
	tprb_lock_detect u_lock (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.compStrobe (compStrobe),
		.compInLock (compInLock),
		.lockFlag   (synthLock)
	);

	// ****************************************
	// Serial slave
	// ****************************************
	// Pin history for edge detection
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= sclIn;
			sdaQ <= sdaIn;
		end
	end

	// Byte framing, acknowledge and read data drive
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q    <= tprb_pkg::ST_IDLE;
			ackPhase_q <= 1'b0;
			bitCnt_q   <= 4'h0;
			rxShift_q  <= 8'h00;
			txShift_q  <= 8'h00;
			subAddr_q  <= 4'h0;
			sdaOe_q    <= 1'b0;
			sdaOut_q   <= 1'b0;
		end else if (busStart) begin
			state_q    <= tprb_pkg::ST_ADDR;
			ackPhase_q <= 1'b0;
			bitCnt_q   <= 4'h0;
			sdaOe_q    <= 1'b0;
		end else if (busStop) begin
			state_q    <= tprb_pkg::ST_IDLE;
			ackPhase_q <= 1'b0;
			sdaOe_q    <= 1'b0;
		end else begin
			case (state_q)
				tprb_pkg::ST_IDLE: begin
					sdaOe_q <= 1'b0;
				end
				tprb_pkg::ST_RD: begin
					if (sclRise && ackPhase_q && sdaIn) begin
						// Master not-acknowledge ends the read
						state_q    <= tprb_pkg::ST_IDLE;
						ackPhase_q <= 1'b0;
					end else if (sclFall && ackPhase_q) begin
						// Next register follows in sequence
						ackPhase_q <= 1'b0;
						subAddr_q  <= nextAddr;
						txShift_q  <= {rdNext[6:0], 1'b0};
						sdaOe_q    <= !rdNext[7];
						bitCnt_q   <= 4'h1;
					end else if (sclFall && byteDone) begin
						ackPhase_q <= 1'b1;
						sdaOe_q    <= 1'b0;
					end else if (sclFall) begin
						sdaOe_q   <= !txShift_q[7];
						txShift_q <= {txShift_q[6:0], 1'b0};
						bitCnt_q  <= bitCnt_q + 4'h1;
					end
				end
				default: begin
					if (sclRise && !ackPhase_q) begin
						rxShift_q <= {rxShift_q[6:0], sdaIn};
						bitCnt_q  <= bitCnt_q + 4'h1;
					end else if (rxEnd) begin
						ackPhase_q <= 1'b1;
						if (state_q == tprb_pkg::ST_ADDR) begin
							sdaOe_q <= addrHit;
							if (!addrHit) begin
								state_q    <= tprb_pkg::ST_IDLE;
								ackPhase_q <= 1'b0;
							end
						end else begin
							sdaOe_q <= 1'b1;
						end
						if (state_q == tprb_pkg::ST_SUB) begin
							subAddr_q <= rxShift_q[3:0];
						end
						if (state_q == tprb_pkg::ST_WR) begin
							subAddr_q <= nextAddr;
						end
					end else if (sclFall && ackPhase_q) begin
						ackPhase_q <= 1'b0;
						bitCnt_q   <= 4'h0;
						sdaOe_q    <= 1'b0;
						if (state_q == tprb_pkg::ST_SUB) begin
							state_q <= tprb_pkg::ST_WR;
						end else if (state_q == tprb_pkg::ST_ADDR &&
							rxShift_q[0]) begin
							state_q   <= tprb_pkg::ST_RD;
							txShift_q <= {rdCur[6:0], 1'b0};
							sdaOe_q   <= !rdCur[7];
							bitCnt_q  <= 4'h1;
						end else if (state_q == tprb_pkg::ST_ADDR) begin
							state_q <= tprb_pkg::ST_SUB;
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// Synthesiser registers
	// ****************************************
	// Divider halves and their pending marks; a write beats the commit clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			divHi_q     <= tprb_pkg::RST_DIVHI;
			divLo_q     <= tprb_pkg::RST_DIVLO;
			divHiNew_q  <= 1'b0;
			divLoNew_q  <= 1'b0;
			loDivider_q <= {tprb_pkg::RST_DIVHI, tprb_pkg::RST_DIVLO};
		end else begin
			if (weDivHi) begin
				divHi_q <= rxShift_q[6:0];
			end
			if (weDivLo) begin
				divLo_q <= rxShift_q;
			end
			divHiNew_q <= weDivHi || (divHiNew_q && !divCommit);
			divLoNew_q <= weDivLo || (divLoNew_q && !divCommit);
			if (divCommit) begin
				loDivider_q <= {divHi_q, divLo_q};
			end
		end
	end

	// Pump, reference and test registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cpRef_q    <= tprb_pkg::RST_CPREF;
			pllTest_q  <= tprb_pkg::RST_PLLTEST;
			cpInUse_q  <= tprb_pkg::RST_CPREF[5:4];
			cpUa_q     <= tprb_pkg::cpMicroamps(tprb_pkg::RST_CPREF[5:4]);
			refRatio_q <= tprb_pkg::refRatio(tprb_pkg::RST_CPREF[3:0]);
		end else begin
			if (weCpRef) begin
				cpRef_q <= rxShift_q;
			end
			if (weTest) begin
				pllTest_q <= rxShift_q;
			end
			cpInUse_q  <= cpStep;
			cpUa_q     <= tprb_pkg::cpMicroamps(cpStep);
			refRatio_q <= tprb_pkg::refRatio(cpRef_q[3:0]);
		end
	end

	// ****************************************
	// RF front end register
	// ****************************************
	// Bypass follows its enable alone, so power down cannot drop it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rfTest_q      <= tprb_pkg::RST_RFTEST;
			bypass_q      <= tprb_pkg::RST_BYPASS;
			rfCut_q       <= tprb_pkg::RST_RFCUT;
			passthrough_q <= tprb_pkg::RST_BYPASS;
			rfTestRo_q    <= 1'b0;
		end else begin
			if (weRf) begin
				rfTest_q <= rxShift_q[6:2];
				bypass_q <= rxShift_q[1];
				rfCut_q  <= rxShift_q[0];
			end
			passthrough_q <= bypass_q;
			rfTestRo_q    <= rfTestIn;
		end
	end

	// ****************************************
	// Baseband registers
	// ****************************************
	// Filter code, adjust control and post-filter gain
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bbFilt_q <= tprb_pkg::RST_BBFILT;
			bbAdj_q  <= tprb_pkg::RST_BBADJ;
			bbGain_q <= tprb_pkg::RST_BBGAIN;
			bbTest_q <= tprb_pkg::RST_BBTEST;
			bbLock_q <= 1'b0;
		end else begin
			if (weBbFilt) begin
				bbFilt_q <= rxShift_q;
			end
			if (weBbAdj) begin
				bbAdj_q <= rxShift_q;
			end
			if (weBbGain) begin
				bbGain_q <= rxShift_q[6:3];
				bbTest_q <= rxShift_q[2:0];
			end
			bbLock_q <= bbAdjustLockIn;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sdaOut               = sdaOut_q;
	assign sdaOe                = sdaOe_q;
	assign loDivider            = loDivider_q;
	assign cpCurrentCode        = cpInUse_q;
	assign cpCurrentUa          = cpUa_q;
	assign refDivRatio          = refRatio_q;
	assign pllTestBits          = cpRef_q[7:6];
	assign pllTestCtl           = pllTest_q;
	assign rfPassthroughOut     = passthrough_q;
	assign rfGainCut            = rfCut_q;
	assign rfTestBits           = rfTest_q;
	assign bbFilterCode         = bbFilt_q;
	assign filterAdjustDisableA = bbAdj_q[6];
	assign filterAdjustDisableB = bbAdj_q[5];
	assign bbRefDivideRatio     = bbAdj_q[4:0];
	assign bbTestBit            = bbAdj_q[7];
	assign postFilterGainSel    = bbGain_q;
	assign bbTestBits           = bbTest_q;
	assign synthLockFlag        = synthLock;

endmodule

// [hdl/tprb_pkg.sv]
/*
 Constants, types and lookups for the tuner PLL, RF and baseband
 register bank. Assumes a single 40 MHz core clock domain.
*/
// Summary of operation
// - Lock flag sets after 64 consecutive in-lock comparison cycles.
// - Reset forces the lock detector output and lock flag to zero.
// - Divider bits 14:8 sit in register 0 bits 6:0, bits 7:0 in register 1.
// - New divider word applies only after both divider registers are written.
// - Register 2: charge pump 5:4, reference select 3:0, test 7:6, reset zero.
// - Charge pump codes map to 400, 550, 750 and 1000 microamps.
// - Charge pump steps to next code when the sub band asks for it.
// - Charge pump readback shows the code actually in use.
// - Reference select decodes via table to 2..256 and 3..320 ratios.
// - Register 4: read-only bit 7, test 6:2 reset 11011, bypass, gain cut.
// - Bypass output stays active whenever enabled, even in power down.
// - Gain cut bit reduces second RF gain section by 10 dB.
// - Register 5 holds filter bandwidth code reset 0x3C for auto adjustment.
// - Register 6: adjust disables at bits 6 and 5, ratio at 4:0.
// - Register 7: read-only adjust lock bit 7, gain 6:3 reset 0111, test 2:0.
// - Post-filter gain is 1.5 dB per code, codes 0 to 11.
// - Writes to read-only bits are ignored.
// - Fixed bus address; sequential bytes go to consecutive registers.
package tprb_pkg;

	// ****************************************
	// Bus and address map
	// ****************************************
	localparam logic [6:0] DEV_ADDR  = 7'h60;
	localparam logic [3:0] A_DIVHI   = 4'h0;
	localparam logic [3:0] A_DIVLO   = 4'h1;
	localparam logic [3:0] A_CPREF   = 4'h2;
	localparam logic [3:0] A_PLLTEST = 4'h3;
	localparam logic [3:0] A_RF      = 4'h4;
	localparam logic [3:0] A_BBFILT  = 4'h5;
	localparam logic [3:0] A_BBADJ   = 4'h6;
	localparam logic [3:0] A_BBGAIN  = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [6:0] RST_DIVHI   = 7'h00;
	localparam logic [7:0] RST_DIVLO   = 8'h00;
	localparam logic [7:0] RST_CPREF   = 8'h00;
	localparam logic [7:0] RST_PLLTEST = 8'h40;
	localparam logic [4:0] RST_RFTEST  = 5'h1B;
	localparam logic       RST_BYPASS  = 1'h1;
	localparam logic       RST_RFCUT   = 1'h0;
	localparam logic [7:0] RST_BBFILT  = 8'h3C;
	localparam logic [7:0] RST_BBADJ   = 8'h08;
	localparam logic [3:0] RST_BBGAIN  = 4'h7;
	localparam logic [2:0] RST_BBTEST  = 3'h0;

	// ****************************************
	// Field limits and lock detection
	// ****************************************
	localparam logic [1:0] CP_TOP     = 2'h3;
	localparam logic [6:0] LOCK_COUNT = 7'h40;

	// ****************************************
	// Serial slave states
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_SUB  = 3'b010,
		ST_WR   = 3'b011,
		ST_RD   = 3'b100
	} tprb_state_t;

	// Charge pump nominal current in microamps
	function automatic logic [9:0] cpMicroamps(input logic [1:0] code);
		case (code)
			2'h0:    cpMicroamps = 10'h190;
			2'h1:    cpMicroamps = 10'h226;
			2'h2:    cpMicroamps = 10'h2EE;
			default: cpMicroamps = 10'h3E8;
		endcase
	endfunction

	// Reference divider ratio lookup
	function automatic logic [8:0] refRatio(input logic [3:0] code);
		case (code)
			4'h0:    refRatio = 9'h002;
			4'h1:    refRatio = 9'h004;
			4'h2:    refRatio = 9'h008;
			4'h3:    refRatio = 9'h010;
			4'h4:    refRatio = 9'h020;
			4'h5:    refRatio = 9'h040;
			4'h6:    refRatio = 9'h080;
			4'h7:    refRatio = 9'h100;
			4'h8:    refRatio = 9'h003;
			4'h9:    refRatio = 9'h005;
			4'hA:    refRatio = 9'h00A;
			4'hB:    refRatio = 9'h014;
			4'hC:    refRatio = 9'h028;
			4'hD:    refRatio = 9'h050;
			4'hE:    refRatio = 9'h0A0;
			default: refRatio = 9'h140;
		endcase
	endfunction

endpackage

// [hdl/tprb_lock_detect.sv]
/*
 Synthesiser lock detector: counts consecutive in-lock comparisons.
 Assumes one compare strobe per comparison cycle, synchronous to core_clk.
*/
`timescale 1ns/1ps
module tprb_lock_detect (
	input  wire logic core_clk,    // Core clock
	input  wire logic rst_n,       // Synchronous reset, active low
	input  wire logic compStrobe,  // One pulse per comparison cycle
	input  wire logic compInLock,  // Comparator lock state for that cycle
	output logic      lockFlag     // Lock detect output
);

	logic [6:0] runCount_q;
	logic [6:0] runCount_d;
	logic       lock_q;
	logic       lock_d;
	wire        runDone = (runCount_q == tprb_pkg::LOCK_COUNT);

	// ****************************************
	// Run counter
	// ****************************************
	// Any out-of-lock comparison restarts the run and drops the flag
	always_comb begin
		runCount_d = runCount_q;
		lock_d     = lock_q;
		if (compStrobe && !compInLock) begin
			runCount_d = 7'h00;
			lock_d     = 1'b0;
		end else if (compStrobe && !runDone) begin
			runCount_d = runCount_q + 7'h01;
		end
		if (runCount_d == tprb_pkg::LOCK_COUNT) begin
			lock_d = 1'b1;
		end
	end

	// Count and flag registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			runCount_q <= 7'h00;
			lock_q     <= 1'b0;
		end else begin
			runCount_q <= runCount_d;
			lock_q     <= lock_d;
		end
	end

	assign lockFlag = lock_q;

endmodule

// [tb/tprb_regs_checker.sv]
/*
 Port assertions bound into tprb_regs.
 Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module tprb_regs_checker (
	input	wire logic		core_clk,		// Core clock
	input	wire logic		rst_n,			// Reset, active low
	input	wire logic		sclIn,			// Serial clock
	input	wire logic		sdaOut,			// Data drive value
	input	wire logic		sdaOe,			// Data drive enable
	input	wire logic		compStrobe,		// Compare pulse
	input	wire logic		compInLock,		// Compare in lock
	input	wire logic [14:0]	loDivider,		// Divider word
	input	wire logic [1:0]	cpCurrentCode,		// Pump code
	input	wire logic [9:0]	cpCurrentUa,		// Pump current
	input	wire logic [8:0]	refDivRatio,		// Reference ratio
	input	wire logic		rfPassthroughOut,	// Bypass output
	input	wire logic		rfGainCut,		// Gain cut
	input	wire logic [7:0]	bbFilterCode,		// Filter code
	input	wire logic [3:0]	postFilterGainSel,	// Gain select
	input	wire logic		synthLockFlag		// Lock flag
);
	// ****************************************
	// Helpers
	// ****************************************
	logic [6:0]	lockRun_q;
	logic [9:0]	uaTab [4] = '{10'h190, 10'h226, 10'h2EE, 10'h3E8};
	// Saturating run of in-lock compares, cleared by reset or a miss
	always_ff @(posedge core_clk) begin
		if (!rst_n || (compStrobe && !compInLock)) begin
			lockRun_q <= 7'h00;
		end else if (compStrobe && lockRun_q != 7'h7F) begin
			lockRun_q <= lockRun_q + 7'h01;
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_lock_set;
		lockRun_q == 7'h40 |-> ##[0:1] synthLockFlag;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock flag late");
	property p_lock_early;
		synthLockFlag |-> lockRun_q >= 7'h40 || $past(lockRun_q) >= 7'h40;
	endproperty
	a_lock_early: assert property (p_lock_early) else $error("lock flag early");
	property p_lock_clear;
		compStrobe && !compInLock |-> ##[1:2] !synthLockFlag;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared");
	property p_reset;
		$rose(rst_n) |-> !synthLockFlag && loDivider == 15'h0000 && refDivRatio == 9'h002
			&& rfPassthroughOut && !rfGainCut && bbFilterCode == 8'h3C
			&& postFilterGainSel == 4'h7;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_div;
		$changed(loDivider) |-> !sclIn;
	endproperty
	a_div: assert property (p_div) else $error("divider moved");
	property p_bypass;
		$changed(rfPassthroughOut) |-> !sclIn && !$past(sclIn);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass moved");
	property p_fields;
		$changed(bbFilterCode) || $changed(postFilterGainSel) || $changed(rfGainCut) |-> !sclIn;
	endproperty
	a_fields: assert property (p_fields) else $error("field moved");
	property p_sda;
		!sdaOut && (!$changed(sdaOe) || !sclIn);
	endproperty
	a_sda: assert property (p_sda) else $error("data drive moved");
	property p_ua;
		$stable(cpCurrentCode) [*2] |-> cpCurrentUa == uaTab[cpCurrentCode];
	endproperty
	a_ua: assert property (p_ua) else $error("pump current");
	property p_ratio;
		refDivRatio inside {9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100,
			9'h003, 9'h005, 9'h00A, 9'h014, 9'h028, 9'h050, 9'h0A0, 9'h140};
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio off table");
	c_lock: cover property ($rose(synthLockFlag));
	c_top: cover property (cpCurrentCode == 2'h3);
	c_ack: cover property ($rose(sdaOe));
endmodule
bind tprb_regs tprb_regs_checker chk (.core_clk, .rst_n, .sclIn, .sdaOut, .sdaOe,
	.compStrobe, .compInLock, .loDivider, .cpCurrentCode, .cpCurrentUa, .refDivRatio,
	.rfPassthroughOut, .rfGainCut, .bbFilterCode, .postFilterGainSel, .synthLockFlag);

// [tb/tprb_host.sv]
/*
 Two-wire bus host model.
 Assumes a pull-up on the bench's data wire.
*/
`timescale 1ns/1ps
module tprb_host (
	input	wire logic	core_clk,	// Core clock
	input	wire logic	sdaIn,		// Resolved data wire
	output	logic		sclIn,		// Serial clock
	output	logic		hostSda		// Data drive, 1 releases
);
	// Bus idles high
	initial begin
		sclIn = 1;
		hostSda = 1;
	end
	// One clock, and a half bit of four clocks
	task automatic tick();
		@(posedge core_clk);
		#2;
	endtask
	task automatic half();
		repeat (4) tick();
	endtask
	// Start (1 to 0) or stop (0 to 1) while the clock is high
	task automatic frame(input logic from, input logic to);
		tick();
		hostSda = from;
		half();
		sclIn = 1;
		half();
		hostSda = to;
		half();
		sclIn = to;
	endtask
	// One bit each way; 1 releases the data wire
	task automatic bitIo(input logic b, output logic s);
		tick();
		hostSda = b;
		half();
		sclIn = 1;
		half();
		s = sdaIn;
		sclIn = 0;
	endtask
	// Bytes, MSB first
	task automatic byteTx(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bitIo(d[i], ack);
		bitIo(1, ack);
	endtask
	task automatic byteRx(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) bitIo(1, d[i]);
		bitIo(nack, s);
	endtask
endmodule

// [tb/tprb_regs_tb.sv]
/*
 Self-checking bench for tprb_regs.
 Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module tprb_regs_tb;
	// ****************************************
	// Signals and design
	// ****************************************
	logic		core_clk = 0, rst_n = 0, sclIn, hostSda, sdaOut, sdaOe, a, o, lockExp;
	logic		compStrobe, compInLock, subBandStep, rfTestIn, bbAdjustLockIn;
	logic		rfPassthroughOut, rfGainCut, filterAdjustDisableA, filterAdjustDisableB;
	logic		bbTestBit, synthLockFlag;
	logic [14:0]	loDivider, divExp, d;
	logic [9:0]	cpCurrentUa, uaTab [4] = '{10'h190, 10'h226, 10'h2EE, 10'h3E8};
	logic [8:0]	refDivRatio;
	logic [7:0]	pllTestCtl, bbFilterCode, sh [16];
	logic [4:0]	rfTestBits, bbRefDivideRatio, r;
	logic [3:0]	postFilterGainSel;
	logic [2:0]	bbTestBits;
	logic [1:0]	cpCurrentCode, pllTestBits, wrMask;
	int		bad_count = 0, n_compared = 0;
	wire		sdaIn = hostSda & ~sdaOe;	// Open drain with pull-up
	always #12.5 core_clk = ~core_clk;
	tprb_regs uut (.*);
	tprb_host h (.core_clk, .sdaIn, .sclIn, .hostSda);
	// ****************************************
	// Expectations and checks
	// ****************************************
	function automatic logic [8:0] refExp(input logic [3:0] c);
		return (c == 4'h8) ? 9'h003 : c[3] ? 9'h005 << (c - 4'h9) : 9'h002 << c;
	endfunction
	function automatic logic [1:0] cpExp();
		return sh[2][5:4] + {1'b0, subBandStep && sh[2][5:4] != 2'h3};
	endfunction
	function automatic logic [7:0] regExp(input int i);
		case (i)
			0: return {lockExp, sh[0][6:0]};
			2: return {sh[2][7:6], cpExp(), sh[2][3:0]};
			4: return {rfTestIn, sh[4][6:0]};
			7: return {bbAdjustLockIn, sh[7][6:0]};
			default: return (i > 7) ? 8'h00 : sh[i];
		endcase
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s %h, want %h", $time, what, seen, exp);
		end
	endtask
	task automatic shadowReset();
		sh = '{3: 8'h40, 4: 8'h6E, 5: 8'h3C, 6: 8'h08, 7: 8'h38, default: 8'h00};
		divExp = 15'h0000;
		wrMask = 2'h0;
		lockExp = 0;
	endtask
	task automatic checkOuts();
		check(loDivider, divExp, "divider");
		check(cpCurrentCode, cpExp(), "pump");
		check(cpCurrentUa, uaTab[cpExp()], "ua");
		check(refDivRatio, refExp(sh[2][3:0]), "ratio");
		check({pllTestBits, pllTestCtl}, {sh[2][7:6], sh[3]}, "pll test");
		check({rfTestBits, rfPassthroughOut, rfGainCut}, sh[4][6:0], "rf");
		check(bbFilterCode, sh[5], "filter");
		check({bbTestBit, filterAdjustDisableA, filterAdjustDisableB, bbRefDivideRatio},
			sh[6], "adjust");
		check({postFilterGainSel, bbTestBits}, sh[7][6:0], "gain");
		check(synthLockFlag, lockExp, "lock");
	endtask
	// ****************************************
	// Bus transactions
	// ****************************************
	task automatic regWrite(input logic [3:0] sub, input logic [7:0] q [$]);
		h.frame(1, 0);
		h.byteTx(8'hC0, a);
		check(a, 0, "write ack");
		h.byteTx({4'h0, sub}, a);
		foreach (q[i]) begin
			h.byteTx(q[i], a);
			sh[sub] = q[i];
			if (sub < 4'h2) wrMask[sub[0]] = 1'b1;
			if (wrMask == 2'h3) begin
				divExp = {sh[0][6:0], sh[1]};
				wrMask = 2'h0;
			end
			sub++;
		end
		h.frame(0, 1);
	endtask
	task automatic readAll();
		logic [7:0] b;
		h.frame(1, 0);
		h.byteTx(8'hC0, a);
		h.byteTx(8'h00, a);
		h.frame(1, 0);
		h.byteTx(8'hC1, a);
		check(a, 0, "read ack");
		for (int i = 0; i < 16; i++) begin
			h.byteRx(b, i == 15);
			check(b, regExp(i), "read");
		end
		h.frame(0, 1);
	endtask
	task automatic strobes(input int n, input logic inLock);
		repeat (n) begin
			compStrobe = 1;
			compInLock = inLock;
			h.tick();
			compStrobe = 0;
			h.tick();
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog at about twice the expected run
	initial begin
		#(25 * 80000);
		bad_count++;
		report_and_stop();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{compStrobe, compInLock, subBandStep, rfTestIn, bbAdjustLockIn} = 5'h00;
		void'($urandom(32'h93a7_8559));
		shadowReset();
		repeat (2) h.tick();
		rst_n = 1;
		checkOuts();
		readAll();
		$display("test reset done");
		// Divider halves in either order, then the range ends
		repeat (4) begin
			d = 15'($urandom_range(32767, 240));
			o = 1'($urandom);
			regWrite(4'(o), {o ? d[7:0] : {1'($urandom), d[14:8]}});
			check(loDivider, divExp, "held");
			regWrite(4'(!o), {!o ? d[7:0] : {1'($urandom), d[14:8]}});
			checkOuts();
		end
		for (int i = 0; i < 2; i++) begin
			d = i ? 15'h7FFF : 15'h00F0;
			regWrite(4'h0, {{1'b1, d[14:8]}, d[7:0]});
			checkOuts();
		end
		$display("test divider done");
		// Every reference code, random pump code and sub band
		for (int c = 0; c < 16; c++) begin
			subBandStep = 1'($urandom);
			regWrite(4'h2, {{2'($urandom), 2'($urandom_range(2, 0)), 4'(c)}});
			checkOuts();
			readAll();
		end
		$display("test pump done");
		// Filter disables cleared before each retune
		repeat (2) begin
			r = 5'($urandom_range(31, 1));
			regWrite(4'h6, {{3'h0, r}});
			rfTestIn = 1'($urandom);
			bbAdjustLockIn = 1'($urandom);
			regWrite(4'h3, {8'h40, 8'($urandom), 8'($urandom), {1'($urandom), 2'h3, r},
				{1'($urandom), 4'($urandom_range(11, 0)), 3'($urandom)}});
			checkOuts();
			readAll();
		end
		h.frame(1, 0);
		h.byteTx(8'hC2, a);
		check(a, 1, "foreign");
		h.frame(0, 1);
		regWrite(4'h9, {8'($urandom)});
		readAll();
		$display("test registers done");
		// Lock needs a full unbroken run, and reset clears it
		strobes(63, 1);
		strobes(1, 0);
		checkOuts();
		strobes(64, 1);
		lockExp = 1;
		checkOuts();
		readAll();
		strobes(1, 0);
		lockExp = 0;
		checkOuts();
		strobes(64, 1);
		rst_n = 0;
		repeat (3) h.tick();
		rst_n = 1;
		shadowReset();
		h.tick();
		checkOuts();
		$display("test lock done");
		report_and_stop();
	end
endmodule
